//--- alc_defines.svh
// Purpose: Constants of the lookup engine control block.
// Assumes: Register indexes times four give the AXI byte address.
// Notes:   Definitions only.
`ifndef ALC_DEFINES_SVH
`define ALC_DEFINES_SVH

// Register indexes; the byte address is the index shifted left by two.
`define ALC_IDX_CTRL0   10'h310
`define ALC_IDX_CTRL1   10'h311
`define ALC_IDX_CTRL2   10'h312
`define ALC_IDX_MAC_LO  10'h314
`define ALC_IDX_MAC_HI  10'h315
`define ALC_IDX_PORT_EN 10'h316
`define ALC_IDX_STATUS  10'h317

// Reset values.
`define ALC_RST_CTRL0   8'h61
`define ALC_RST_CTRL1   8'h0C
`define ALC_RST_CTRL2   8'h00
// Age count output after reset, the reset value of its field.
`define ALC_RST_AGE     3'h4

// Field positions of the second control register.
`define ALC_B_LEARN_DIS 7
`define ALC_B_SELF_FILT 6
`define ALC_B_FLUSH_ALL 5
`define ALC_B_FLUSH_MST 4
`define ALC_B_MC_FWD    3
`define ALC_B_AGE_EN    2
`define ALC_B_FAST_AGE  1
`define ALC_B_LINK_FL   0
// Age count field of the first control register.
`define ALC_AGE_HI      5
`define ALC_AGE_LO      3
// Flush scope field of the third control register.
`define ALC_SCOPE_HI    3
`define ALC_SCOPE_LO    2
// Group bit of a source address sent first octet first.
`define ALC_SA_GROUP    40

// Sizes and answers.
`define ALC_NPORT       7
`define ALC_RESP_OKAY   2'h0
`define ALC_RESP_SLVERR 2'h2

`endif

//--- alc_pkg.sv
// Purpose: Types of the lookup engine control block.
// Assumes: Used by the control block and its bench.
// Notes:   Constants stay in the defines header.
package alc_pkg;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    ALC_R_NONE, ALC_R_CTRL0, ALC_R_CTRL1, ALC_R_CTRL2,
    ALC_R_MAC_LO, ALC_R_MAC_HI, ALC_R_PORT_EN, ALC_R_STATUS
  } alc_reg_t;

  // Flush engine states.
  typedef enum logic {ALC_FL_IDLE, ALC_FL_BUSY} alc_fl_state_t;

  // Kind of flush handed to the table engine.
  typedef enum logic [1:0] {ALC_FK_ALL, ALC_FK_MSTP, ALC_FK_PORT} alc_fl_kind_t;

  // Flush scope codes.
  typedef enum logic [1:0] {
    ALC_SC_NONE = 2'h0, ALC_SC_DYN = 2'h1, ALC_SC_STAT = 2'h2, ALC_SC_BOTH = 2'h3
  } alc_scope_t;

endpackage

//--- alc_control.sv
// Purpose: Lookup engine control registers with flush sequencing and
//          source address filtering, reached over AXI4-Lite.
// Assumes: All inputs are synchronous to clock; the table engine holds
//          each flush request until it pulses flush_done.
// Notes:   One write and one read are handled at a time.
`timescale 1ns/1ps
`include "alc_defines.svh"

module alc_control
  import alc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite slave.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Source address check from the ingress path.
  input  wire logic        sa_valid,
  input  wire logic [47:0] sa_addr,
  input  wire logic [2:0]  sa_port,
  output logic             sa_done_q,
  output logic             sa_drop_q,
  output logic             sa_learn_q,
  // Port link state.
  input  wire logic [6:0]  link_up,
  // Flush handshake with the table engine.
  output logic             flush_req_q,
  output logic [1:0]       flush_kind_q,
  output logic [1:0]       flush_scope_q,
  output logic [2:0]       flush_port_q,
  input  wire logic        flush_done,
  // Aging controls.
  output logic             aging_en_q,
  output logic             fast_aging_q,
  output logic [2:0]       age_count_q
);

  // Maps a byte address onto a register; misaligned addresses are unmapped.
  function automatic alc_reg_t reg_sel(input logic [11:0] a);
    if (a[1:0] != 2'h0) return ALC_R_NONE;
    unique case (a[11:2])
      `ALC_IDX_CTRL0:   return ALC_R_CTRL0;
      `ALC_IDX_CTRL1:   return ALC_R_CTRL1;
      `ALC_IDX_CTRL2:   return ALC_R_CTRL2;
      `ALC_IDX_MAC_LO:  return ALC_R_MAC_LO;
      `ALC_IDX_MAC_HI:  return ALC_R_MAC_HI;
      `ALC_IDX_PORT_EN: return ALC_R_PORT_EN;
      `ALC_IDX_STATUS:  return ALC_R_STATUS;
      default:          return ALC_R_NONE;
    endcase
  endfunction

  // Merges written bytes into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // Lowest numbered port with a pending link-down flush.
  function automatic logic [2:0] first_port(input logic [6:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (p[i]) r = 3'(i);
    end
    return r;
  endfunction

  // Write channel holding registers.
  logic             aw_hold_q;   // Write address taken and waiting.
  logic [11:0]      awaddr_q;    // Taken write address.
  logic             w_hold_q;    // Write data taken and waiting.
  logic [31:0]      wdata_q;     // Taken write data.
  logic [3:0]       wstrb_q;     // Taken byte strobes.
  // Register file.
  logic [7:0]       ctrl0_q;     // Lookup control, holds the age count.
  logic [7:0]       ctrl1_q;     // Main lookup control register.
  logic [7:0]       ctrl2_q;     // Lookup control, holds the flush scope.
  logic [47:0]      mac_q;       // Station address.
  logic [6:0]       port_en_q;   // Per-port self filter enables.
  logic [6:0]       port_pend_q; // Ports waiting for a link-down flush.
  logic [6:0]       link_q;      // Link state of the previous cycle.
  alc_fl_state_t    fl_st_q;     // Flush engine state.

  // Bus handshakes.
  wire        aw_fire = s_axi_awvalid & s_axi_awready;
  wire        w_fire  = s_axi_wvalid & s_axi_wready;
  wire        ar_fire = s_axi_arvalid & s_axi_arready;
  // Both halves of a write are present and the previous answer is gone.
  wire        wr_go   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire        aw_hold_d = wr_go ? 1'b0 : (aw_fire | aw_hold_q);
  wire        w_hold_d  = wr_go ? 1'b0 : (w_fire | w_hold_q);
  wire        rvalid_d  = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  wire alc_reg_t wsel  = reg_sel(awaddr_q);
  wire alc_reg_t rsel  = reg_sel(s_axi_araddr);
  // Eight-bit registers and the port enables take writes only when byte lane 0 is written.
  wire        lane0    = wr_go & wstrb_q[0];
  wire        wr_ctrl0 = lane0 & (wsel == ALC_R_CTRL0);
  wire        wr_ctrl1 = lane0 & (wsel == ALC_R_CTRL1);
  wire        wr_ctrl2 = lane0 & (wsel == ALC_R_CTRL2);
  wire        wr_mlo   = wr_go & (wsel == ALC_R_MAC_LO);
  wire        wr_mhi   = wr_go & (wsel == ALC_R_MAC_HI);
  wire        wr_pen   = lane0 & (wsel == ALC_R_PORT_EN);
  wire [31:0] mlo_new  = merge(mac_q[31:0], wdata_q, wstrb_q);
  wire [31:0] mhi_new  = merge({16'h0000, mac_q[47:32]}, wdata_q, wstrb_q);

  // Flush source selection: a software flush beats a spanning-tree flush,
  // which beats link-down flushes taken in port order.
  wire [1:0]  scope    = ctrl2_q[`ALC_SCOPE_HI:`ALC_SCOPE_LO];
  wire        any_pend = ctrl1_q[`ALC_B_FLUSH_ALL] | ctrl1_q[`ALC_B_FLUSH_MST] |
                         (|port_pend_q);
  wire [1:0]  pick_kind = ctrl1_q[`ALC_B_FLUSH_ALL] ? ALC_FK_ALL :
                          ctrl1_q[`ALC_B_FLUSH_MST] ? ALC_FK_MSTP : ALC_FK_PORT;
  wire [2:0]  pick_port = first_port(port_pend_q);
  wire        idle     = (fl_st_q == ALC_FL_IDLE);
  // Scope 00 flushes nothing, so the trigger completes at once.
  wire        skip     = idle & any_pend & (scope == ALC_SC_NONE);
  wire        start    = idle & any_pend & (scope != ALC_SC_NONE);
  wire        finish   = ~idle & flush_done;
  wire        svc_end  = skip | finish;
  wire [1:0]  cur_kind = idle ? pick_kind : flush_kind_q;
  wire [2:0]  cur_port = idle ? pick_port : flush_port_q;
  wire        clr_all  = svc_end & (cur_kind == ALC_FK_ALL);
  wire        clr_mst  = svc_end & (cur_kind == ALC_FK_MSTP);
  wire [6:0]  clr_port = (svc_end & (cur_kind == ALC_FK_PORT)) ?
                         7'(8'h01 << cur_port) : 7'h00;
  wire [6:0]  link_fall = link_q & ~link_up;
  // A link loss in the cycle its flush finishes stays pending.
  wire [6:0]  port_pend_d = (port_pend_q & ~clr_port) |
                            (link_fall & {7{ctrl1_q[`ALC_B_LINK_FL]}});

  // Trigger bits: a new write of 1 wins over the completion that clears it.
  wire        fa_d = (ctrl1_q[`ALC_B_FLUSH_ALL] & ~clr_all) |
                     (wr_ctrl1 & wdata_q[`ALC_B_FLUSH_ALL]);
  wire        fm_d = (ctrl1_q[`ALC_B_FLUSH_MST] & ~clr_mst) |
                     (wr_ctrl1 & wdata_q[`ALC_B_FLUSH_MST]);
  wire [7:0]  ctrl1_d = wr_ctrl1 ?
                        {wdata_q[7:6], fa_d, fm_d, wdata_q[3:0]} :
                        {ctrl1_q[7:6], fa_d, fm_d, ctrl1_q[3:0]};

  // Source address decisions.
  wire        sa_group = sa_addr[`ALC_SA_GROUP];
  wire [7:0]  pen_ext  = {1'b0, port_en_q};
  wire        self_hit = ctrl1_q[`ALC_B_SELF_FILT] & pen_ext[sa_port] &
                         (sa_addr == mac_q);
  wire        mc_drop  = sa_group & ~ctrl1_q[`ALC_B_MC_FWD];
  wire        drop     = self_hit | mc_drop;
  wire        learn    = ~drop & ~sa_group & ~ctrl1_q[`ALC_B_LEARN_DIS];

  // Read multiplexer; unmapped reads return zero with an error answer.
  wire [31:0] status_w = {24'h000000, port_pend_q, ~idle};
  wire [31:0] rd_mux =
    (rsel == ALC_R_CTRL0)   ? {24'h000000, ctrl0_q} :
    (rsel == ALC_R_CTRL1)   ? {24'h000000, ctrl1_q} :
    (rsel == ALC_R_CTRL2)   ? {24'h000000, ctrl2_q} :
    (rsel == ALC_R_MAC_LO)  ? mac_q[31:0] :
    (rsel == ALC_R_MAC_HI)  ? {16'h0000, mac_q[47:32]} :
    (rsel == ALC_R_PORT_EN) ? {25'h0000000, port_en_q} :
    (rsel == ALC_R_STATUS)  ? status_w : 32'h00000000;

  // Bus channel registers; ready drops while a beat is held.
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ALC_RESP_OKAY;
    end else begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      s_axi_awready <= ~aw_hold_d;
      s_axi_wready  <= ~w_hold_d;
      if (aw_fire) awaddr_q <= s_axi_awaddr;
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == ALC_R_NONE) ? `ALC_RESP_SLVERR : `ALC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data is captured on the address handshake.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ALC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_fire) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (rsel == ALC_R_NONE) ? `ALC_RESP_SLVERR : `ALC_RESP_OKAY;
      end
    end
  end

  // Register file updates. The station address defaults to zero, which
  // means no real frame matches it until software programs it.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl0_q     <= `ALC_RST_CTRL0;
      ctrl1_q     <= `ALC_RST_CTRL1;
      ctrl2_q     <= `ALC_RST_CTRL2;
      mac_q       <= 48'h000000000000;
      port_en_q   <= 7'h00;
      port_pend_q <= 7'h00;
      link_q      <= 7'h00;
    end else begin
      ctrl1_q     <= ctrl1_d;
      port_pend_q <= port_pend_d;
      link_q      <= link_up;
      if (wr_ctrl0) ctrl0_q <= wdata_q[7:0];
      if (wr_ctrl2) ctrl2_q <= wdata_q[7:0];
      if (wr_mlo) mac_q[31:0] <= mlo_new;
      if (wr_mhi) mac_q[47:32] <= mhi_new[15:0];
      if (wr_pen) port_en_q <= wdata_q[6:0];
    end
  end

  // Flush engine: one request at a time, held until the table answers.
  always_ff @(posedge clock) begin
    if (rst) begin
      fl_st_q       <= ALC_FL_IDLE;
      flush_req_q   <= 1'b0;
      flush_kind_q  <= ALC_FK_ALL;
      flush_scope_q <= ALC_SC_NONE;
      flush_port_q  <= 3'h0;
    end else begin
      unique case (fl_st_q)
        ALC_FL_IDLE: begin
          if (start) begin
            fl_st_q       <= ALC_FL_BUSY;
            flush_req_q   <= 1'b1;
            flush_kind_q  <= pick_kind;
            flush_scope_q <= scope;
            flush_port_q  <= pick_port;
          end
        end
        ALC_FL_BUSY: begin
          if (finish) begin
            fl_st_q     <= ALC_FL_IDLE;
            flush_req_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Frame verdicts and aging levels, all registered.
  always_ff @(posedge clock) begin
    if (rst) begin
      sa_done_q    <= 1'b0;
      sa_drop_q    <= 1'b0;
      sa_learn_q   <= 1'b0;
      aging_en_q   <= 1'b1;
      fast_aging_q <= 1'b0;
      age_count_q  <= `ALC_RST_AGE;
    end else begin
      sa_done_q    <= sa_valid;
      sa_drop_q    <= sa_valid & drop;
      sa_learn_q   <= sa_valid & learn;
      aging_en_q   <= ctrl1_q[`ALC_B_AGE_EN];
      // Fast aging is meaningless while aging itself is stopped.
      fast_aging_q <= ctrl1_q[`ALC_B_AGE_EN] & ctrl1_q[`ALC_B_FAST_AGE];
      age_count_q  <= ctrl0_q[`ALC_AGE_HI:`ALC_AGE_LO];
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A flush that the table answers must drop its request at the next edge.
  sequence s_flush_open;  flush_req_q && !flush_done; endsequence
  sequence s_flush_close; flush_req_q && flush_done;  endsequence

  property p_learn_off;
    sa_valid && ctrl1_q[`ALC_B_LEARN_DIS] |=> sa_done_q && !sa_learn_q;
  endproperty
  a_learn_off: assert property (p_learn_off) else $error("learned while disabled");
  property p_self_drop; sa_valid && self_hit |=> sa_drop_q && !sa_learn_q; endproperty
  a_self_drop: assert property (p_self_drop) else $error("self frame kept");
  property p_self_global;
    sa_valid && !ctrl1_q[`ALC_B_SELF_FILT] && !sa_group |=> !sa_drop_q;
  endproperty
  a_self_global: assert property (p_self_global) else $error("filtered when off");
  property p_flush_all;
    idle && ctrl1_q[`ALC_B_FLUSH_ALL] && scope != 2'h0
      |=> flush_req_q && flush_kind_q == ALC_FK_ALL;
  endproperty
  a_flush_all: assert property (p_flush_all) else $error("full flush missing");
  property p_scope;
    $rose(flush_req_q) |-> flush_scope_q == $past(scope) && flush_scope_q != 2'h0;
  endproperty
  a_scope: assert property (p_scope) else $error("flush scope wrong");
  property p_no_scope; idle && any_pend && scope == 2'h0 |=> !flush_req_q; endproperty
  a_no_scope: assert property (p_no_scope) else $error("flush with scope 00");
  property p_flush_mstp;
    idle && !ctrl1_q[`ALC_B_FLUSH_ALL] && ctrl1_q[`ALC_B_FLUSH_MST] && scope != 2'h0
      |=> flush_req_q && flush_kind_q == ALC_FK_MSTP;
  endproperty
  a_flush_mstp: assert property (p_flush_mstp) else $error("tree flush missing");
  property p_mc_drop; sa_valid && sa_group && !ctrl1_q[`ALC_B_MC_FWD] |=> sa_drop_q; endproperty
  a_mc_drop: assert property (p_mc_drop) else $error("group source kept");
  property p_age_off; !ctrl1_q[`ALC_B_AGE_EN] |=> !aging_en_q && !fast_aging_q; endproperty
  a_age_off: assert property (p_age_off) else $error("aging while off");
  property p_fast;
    ctrl1_q[`ALC_B_AGE_EN] && ctrl1_q[`ALC_B_FAST_AGE] |=> fast_aging_q && aging_en_q;
  endproperty
  a_fast: assert property (p_fast) else $error("fast aging missing");
  property p_fast_gate;
    ctrl1_q[`ALC_B_FAST_AGE] && !ctrl1_q[`ALC_B_AGE_EN] |=> !fast_aging_q;
  endproperty
  a_fast_gate: assert property (p_fast_gate) else $error("fast aging while off");
  property p_link_flush;
    ctrl1_q[`ALC_B_LINK_FL] && (|link_fall) |=> (|port_pend_q) || flush_req_q;
  endproperty
  a_link_flush: assert property (p_link_flush) else $error("link loss ignored");
  property p_read_ctrl1;
    ar_fire && rsel == ALC_R_CTRL1 |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(ctrl1_q)};
  endproperty
  a_read_ctrl1: assert property (p_read_ctrl1) else $error("control read wrong");
  property p_age_cnt; ##1 age_count_q == $past(ctrl0_q[`ALC_AGE_HI:`ALC_AGE_LO]); endproperty
  a_age_cnt: assert property (p_age_cnt) else $error("age count stale");
  property p_self_clear;
    s_flush_open ##1 s_flush_close |=> !flush_req_q && idle;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("flush not ended");

endmodule // alc_control

//--- tb.sv
// Purpose: Self-checking bench for the lookup engine control block.
// Assumes: The AXI byte address is the register index times four.
// Notes:   A bench model of the control bits predicts the frame verdicts and flush readbacks.
`timescale 1ns/1ps

module tb import alc_pkg::*; ;
  // Design inputs, each given a value at time zero.
  logic        clock = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        sa_valid = 1'b0, flush_done = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [47:0] sa_addr = 48'h0;
  logic [2:0]  sa_port = 3'h0;
  logic [6:0]  link_up = 7'h7F;
  // Design outputs.
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, flush_kind_q, flush_scope_q;
  logic [31:0] s_axi_rdata;
  logic        sa_done_q, sa_drop_q, sa_learn_q, flush_req_q, aging_en_q, fast_aging_q;
  logic [2:0]  flush_port_q, age_count_q;
  // Bench model of the control register, station address and port enables.
  int          mismatches = 0, n_compared = 0, seed = 39264;
  logic [7:0]  c1_m = 8'h0C;
  logic [47:0] st_m, a48;
  logic [6:0]  pen_m;

  alc_control u_alc_control (
    .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sa_valid(sa_valid), .sa_addr(sa_addr), .sa_port(sa_port), .sa_done_q(sa_done_q),
    .sa_drop_q(sa_drop_q), .sa_learn_q(sa_learn_q), .link_up(link_up),
    .flush_req_q(flush_req_q), .flush_kind_q(flush_kind_q), .flush_scope_q(flush_scope_q),
    .flush_port_q(flush_port_q), .flush_done(flush_done), .aging_en_q(aging_en_q),
    .fast_aging_q(fast_aging_q), .age_count_q(age_count_q));

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Case equality, so an unknown never passes for a match.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One write; address and data are released each when taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  // One read; data and response are taken at the edge that ends it.
  task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, e});
  endtask

  // One source address judgement, answered exactly one cycle later.
  task automatic sa_run(input logic [47:0] a, input logic [2:0] p);
    logic dr;
    @(posedge clock);
    sa_valid <= 1'b1;
    sa_addr <= a;
    sa_port <= p;
    @(posedge clock);
    sa_valid <= 1'b0;
    @(posedge clock);
    dr = (c1_m[6] & pen_m[p] & (a == st_m)) | (a[40] & ~c1_m[3]);
    chk({sa_done_q, sa_drop_q, sa_learn_q}, {1'b1, dr, ~a[40] & ~dr & ~c1_m[7]});
  endtask

  // Raise one flush source (a trigger bit, or link loss when tr is zero)
  // and complete it as the table engine would.
  task automatic fl_run(input logic [1:0] sc, input logic [7:0] tr, input logic [1:0] k,
                        input logic [2:0] p);
    int n;
    n = 0;
    axw(12'hC48, {28'h0, sc, 2'h0}, 2'h0);
    if (tr != 8'h00) begin
      axw(12'hC44, {24'h0, c1_m | tr}, 2'h0);
    end else begin
      @(posedge clock);
      link_up[p] <= 1'b0;
    end
    while (!flush_req_q && n < 8) begin
      @(posedge clock);
      n++;
    end
    if (sc == 2'h0) begin
      chk(flush_req_q, 1'b0);
    end else begin
      chk({flush_req_q, flush_kind_q, flush_scope_q}, {1'b1, k, sc});
      if (k == 2'h2) chk(flush_port_q, p);
      axr(12'hC44, {24'h0, c1_m | tr}, 2'h0);
      // Status shows the engine busy and any port still waiting for its flush.
      axr(12'hC5C, {24'h0, ((k == 2'h2) ? 8'(8'h02 << p) : 8'h00) | 8'h01}, 2'h0);
      @(posedge clock);
      flush_done <= 1'b1;
      @(posedge clock);
      flush_done <= 1'b0;
      @(posedge clock);
      chk(flush_req_q, 1'b0);
    end
    axr(12'hC44, {24'h0, c1_m}, 2'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few thousand cycles at most.
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    axr(12'hC44, 32'h0C, 2'h0);
    axr(12'hC40, 32'h61, 2'h0);
    axr(12'hC48, 32'h00, 2'h0);
    axr(12'hC60, 32'h00, 2'h2);
    chk({aging_en_q, fast_aging_q, age_count_q}, {2'b10, 3'h4});
    axw(12'hC40, 32'h79, 2'h0);
    @(posedge clock);
    chk(age_count_q, 3'h7);
    axw(12'hC64, 32'hFF, 2'h2);
    axr(12'hC45, 32'h00, 2'h2);
    // A write without byte lane 0 must leave the control register alone.
    s_axi_wstrb <= 4'hE;
    axw(12'hC44, 32'hFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    axr(12'hC44, 32'h0C, 2'h0);
    // Every pairing of aging enable and fast aging.
    for (int i = 0; i < 4; i++) begin
      c1_m = {4'h0, 1'b1, i[1], i[0], 1'b0};
      axw(12'hC44, {24'h0, c1_m}, 2'h0);
      @(posedge clock);
      chk({aging_en_q, fast_aging_q}, {i[1], i[1] & i[0]});
    end
    // Random station address and port enables, then judgements per control mix.
    st_m = {16'($random(seed)), 32'($random(seed))};
    pen_m = 7'($random(seed));
    axw(12'hC50, st_m[31:0], 2'h0);
    axw(12'hC54, {16'h0, st_m[47:32]}, 2'h0);
    axw(12'hC58, {25'h0, pen_m}, 2'h0);
    for (int k = 0; k < 8; k++) begin
      c1_m = {k[2], k[1], 2'b00, k[0], 3'b100};
      axw(12'hC44, {24'h0, c1_m}, 2'h0);
      for (int j = 0; j < 8; j++) begin
        a48 = {16'($random(seed)), 32'($random(seed))};
        if (j[0]) a48 = st_m;
        sa_run(a48, 3'(j % 7));
      end
    end
    // Flush of the whole table under every scope code, then the instance flush.
    c1_m = 8'h0C;
    axw(12'hC44, 32'h0C, 2'h0);
    for (int s = 0; s < 4; s++) begin
      fl_run(s[1:0], 8'h20, ALC_FK_ALL, 3'h0);
    end
    fl_run(2'h1, 8'h10, ALC_FK_MSTP, 3'h0);
    // Link loss must not flush while the link flush bit is clear.
    @(posedge clock);
    link_up <= 7'h77;
    repeat (6) @(posedge clock);
    chk(flush_req_q, 1'b0);
    link_up <= 7'h7F;
    c1_m = 8'h0D;
    axw(12'hC44, 32'h0D, 2'h0);
    fl_run(2'h2, 8'h00, ALC_FK_PORT, 3'h5);
    finish_test();
  end
endmodule // tb
